// ==== pin_sync.v ====
// Two-stage synchroniser for package pin inputs.
`timescale 1ns/1ns
module pin_sync #(
   parameter WIDTH = 13
) (
   input wire clk_i,
   input wire rst_i,
   input wire [WIDTH-1:0] d_i,
   output wire [WIDTH-1:0] q_o
);
   reg [WIDTH-1:0] meta_reg;
   reg [WIDTH-1:0] sync_reg;

   // ------------------------------------------------------------
   // Synchroniser stages
   // ------------------------------------------------------------
   // Pins idle high, so both stages reset to ones.
   always @(posedge clk_i) begin
      if (rst_i) begin
         meta_reg <= {WIDTH{1'b1}};
         sync_reg <= {WIDTH{1'b1}};
      end else begin
         meta_reg <= d_i;
         sync_reg <= meta_reg;
      end
   end

   assign q_o = sync_reg;
endmodule

// ==== pin_world.sv ====
// Package pin model for ports A and B.
`timescale 1ns/1ns
module pin_world (
   input wire [7:0] pa_out_i,
   input wire [7:0] pa_oe_n_i,
   input wire [4:0] pb_out_i,
   input wire [4:0] pb_oe_n_i,
   input wire [7:0] pa_board_i,
   input wire [4:0] pb_board_i,
   output wire [7:0] pa_pin_o,
   output wire [4:0] pb_pin_o
);
   assign pa_pin_o = (pa_out_i & ~pa_oe_n_i) | (pa_board_i & pa_oe_n_i);
   assign pb_pin_o = (pb_out_i & ~pb_oe_n_i) | (pb_board_i & pb_oe_n_i);
endmodule

// ==== port_b_pin_mux.v ====
// Port B pin-function mux, input-source routing, GPIO ports and port A wake-up.
//
// Notes on behaviour
// - PB3 field: GPIO, powerline receive, serial data.
// - PB2 field: GPIO, powerline sink, serial clock.
// - PB1 field: GPIO, powerline transmit, serial data out.
// - PB0 field: GPIO/irq0, chip select, timer, opamp.
// - High select bits 7..2 read as zero.
// - PB4: code 01 chip select, else GPIO.
// - Capture input from PA7 on 01, else comparator.
// - Chip-select source: PB0, PB4 or PA1.
// - Serial clock source: PA0, PB2 or PA7.
// - SPI master drives clock on PA0, PA7, PB2.
// - Serial data source: PA2, PA6 or PB3.
// - Reset sets data and direction to ones.
// - Unwritten latch drives high on output.
// - Bit set/clear reads, modifies, writes whole byte.
// - Enabled port A falling edge wakes in sleep.
// - Direction one input; outputs read the latch.
// - Wake enable bit one enables its pin.
//
// The implementer's own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ns
`include "port_mux_map.vh"
module port_b_pin_mux (
   input wire clk_i,
   input wire rst_i,
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [7:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output reg ack_o,
   input wire [`PA_W-1:0] pa_in_i,
   output reg [`PA_W-1:0] pa_out_o,
   output reg [`PA_W-1:0] pa_oe_n_o,
   input wire [`PB_W-1:0] pb_in_i,
   output reg [`PB_W-1:0] pb_out_o,
   output reg [`PB_W-1:0] pb_oe_n_o,
   input wire sleep_i,
   output reg wake_o,
   input wire powerline_transmit_out_i,
   input wire serial_data_out_i,
   input wire serial_clock_out_i,
   input wire standard_timer_out_i,
   input wire powerline_comparator_out_i,
   output reg powerline_receive_in_o,
   output reg serial_data_in_o,
   output reg serial_clock_in_o,
   output reg serial_chip_select_o,
   output reg periodic_timer_capture_in_o,
   output reg external_irq0_o,
   output reg powerline_sink_node_sel_o,
   output reg opamp0_inverting_in_sel_o
);
   localparam S_IDLE = 2'd0;
   localparam S_MODIFY = 2'd1;

   reg [1:0] state_reg;
   reg [7:0] pa_data_reg, pa_dir_reg, porta_wake_enable_reg, portb_low_pin_select_reg, input_source_select_reg;
   reg [`PB_W-1:0] pb_data_reg, pb_dir_reg;
   reg [1:0] portb_high_pin_select_reg;
   reg [`CTRL_W-1:0] ctrl_reg;
   reg [7:0] rmw_byte_reg;
   reg [5:0] rmw_idx_reg;
   reg [2:0] rmw_bit_reg;
   reg rmw_set_reg;
   reg [`PA_W-1:0] pa_prev_reg;
   wire [`PA_W+`PB_W-1:0] pin_sync_q;
   wire [`PA_W-1:0] pa_s;
   wire [`PB_W-1:0] pb_s;
   wire [5:0] bus_idx;
   wire req, accept, spi_master_on;
   wire [7:0] pa_read, pb_read, rmw_mask, rmw_new;
   wire [1:0] f3, f2, f1, f0, f4;
   reg wr_go;
   reg [5:0] wr_idx;
   reg [7:0] wr_val;
   reg [`PA_W-1:0] pa_out_next, pa_oe_n_next;
   reg [`PB_W-1:0] pb_out_next, pb_oe_n_next;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   pin_sync #(
      .WIDTH(`PA_W + `PB_W)
   ) u_pin_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i({pb_in_i, pa_in_i}),
      .q_o(pin_sync_q)
   );

   assign pa_s = pin_sync_q[`PA_W-1:0];
   assign pb_s = pin_sync_q[`PA_W+`PB_W-1:`PA_W];
   assign f3 = portb_low_pin_select_reg[`PB3_HI:`PB3_LO];
   assign f2 = portb_low_pin_select_reg[`PB2_HI:`PB2_LO];
   assign f1 = portb_low_pin_select_reg[`PB1_HI:`PB1_LO];
   assign f0 = portb_low_pin_select_reg[`PB0_HI:`PB0_LO];
   assign f4 = portb_high_pin_select_reg;
   assign spi_master_on = ctrl_reg[`CTRL_SIM_EN] & ctrl_reg[`CTRL_SPI_MASTER];

   // ------------------------------------------------------------
   // Register read decode
   // ------------------------------------------------------------
   // Port read path: input pins return pin level, outputs the latch.
   assign pa_read = (pa_dir_reg & pa_s) | (~pa_dir_reg & pa_data_reg);
   assign pb_read = {3'h0, (pb_dir_reg & pb_s) | (~pb_dir_reg & pb_data_reg)};
   function [7:0] reg_read;
      input [5:0] idx;
      begin
         case (idx)
            `IDX_PA_DATA: reg_read = pa_read;
            `IDX_PA_DIR: reg_read = pa_dir_reg;
            `IDX_PB_DATA: reg_read = pb_read;
            `IDX_PB_DIR: reg_read = {3'h0, pb_dir_reg};
            `IDX_PA_WAKE: reg_read = porta_wake_enable_reg;
            `IDX_PBS_LOW: reg_read = portb_low_pin_select_reg;
            `IDX_PBS_HIGH: reg_read = {6'h00, portb_high_pin_select_reg};
            `IDX_IFS: reg_read = input_source_select_reg;
            `IDX_CTRL: reg_read = {4'h0, ctrl_reg};
            default: reg_read = 8'h00;
         endcase
      end
   endfunction

   // ------------------------------------------------------------
   // Wishbone slave and bit operation sequencer
   // ------------------------------------------------------------
   assign bus_idx = adr_i[7:2];
   assign req = cyc_i & stb_i & ~ack_o;
   assign accept = req & (state_reg == S_IDLE);

   assign rmw_mask = 8'h01 << rmw_bit_reg;
   assign rmw_new = rmw_set_reg ? (rmw_byte_reg | rmw_mask) : (rmw_byte_reg & ~rmw_mask);

   always @* begin
      wr_go = 1'b0;
      wr_idx = bus_idx;
      wr_val = dat_i[7:0];
      if (state_reg == S_MODIFY) begin
         wr_go = 1'b1;
         wr_idx = rmw_idx_reg;
         wr_val = rmw_new;
      end else if (accept && we_i && sel_i[0] && bus_idx != `IDX_BITOP) begin
         wr_go = 1'b1;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= S_IDLE;
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
         rmw_byte_reg <= 8'h00;
         rmw_idx_reg <= 6'h00;
         rmw_bit_reg <= 3'h0;
         rmw_set_reg <= 1'b0;
      end else begin
         ack_o <= 1'b0;
         case (state_reg)
            S_IDLE: begin
               if (accept) begin
                  if (we_i && sel_i[0] && bus_idx == `IDX_BITOP) begin
                     rmw_idx_reg <= {3'h0, dat_i[`BITOP_TGT_HI:`BITOP_TGT_LO]};
                     rmw_byte_reg <= reg_read({3'h0, dat_i[`BITOP_TGT_HI:`BITOP_TGT_LO]});
                     rmw_bit_reg <= dat_i[`BITOP_BIT_HI:`BITOP_BIT_LO];
                     rmw_set_reg <= dat_i[`BITOP_SET];
                     state_reg <= S_MODIFY;
                  end else begin
                     ack_o <= 1'b1;
                     if (!we_i) begin
                        dat_o <= {24'h000000, reg_read(bus_idx)};
                     end
                  end
               end
            end
            S_MODIFY: begin
               ack_o <= 1'b1;
               state_reg <= S_IDLE;
            end
            default: begin
               state_reg <= S_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         pa_data_reg <= `RST_DATA;
         pa_dir_reg <= `RST_DIR;
         pb_data_reg <= `RST_PB;
         pb_dir_reg <= `RST_PB;
         porta_wake_enable_reg <= `RST_ZERO;
         portb_low_pin_select_reg <= `RST_ZERO;
         portb_high_pin_select_reg <= 2'h0;
         input_source_select_reg <= `RST_ZERO;
         ctrl_reg <= 4'h0;
      end else if (wr_go) begin
         case (wr_idx)
            `IDX_PA_DATA: pa_data_reg <= wr_val;
            `IDX_PA_DIR: pa_dir_reg <= wr_val;
            `IDX_PB_DATA: pb_data_reg <= wr_val[`PB_W-1:0];
            `IDX_PB_DIR: pb_dir_reg <= wr_val[`PB_W-1:0];
            `IDX_PA_WAKE: porta_wake_enable_reg <= wr_val;
            `IDX_PBS_LOW: portb_low_pin_select_reg <= wr_val;
            `IDX_PBS_HIGH: portb_high_pin_select_reg <= wr_val[1:0];
            `IDX_IFS: input_source_select_reg <= wr_val;
            `IDX_CTRL: ctrl_reg <= wr_val[`CTRL_W-1:0];
            default: ctrl_reg <= ctrl_reg;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Port A pin drivers
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `PA_W; gi = gi + 1) begin : g_pa
         always @* begin
            pa_out_next[gi] = pa_data_reg[gi];
            pa_oe_n_next[gi] = pa_dir_reg[gi];
            if (gi == 0 && spi_master_on && ctrl_reg[`CTRL_PA0_SCK]) begin
               pa_out_next[gi] = serial_clock_out_i;
               pa_oe_n_next[gi] = 1'b0;
            end
            if (gi == 7 && spi_master_on && ctrl_reg[`CTRL_PA7_SCK]) begin
               pa_out_next[gi] = serial_clock_out_i;
               pa_oe_n_next[gi] = 1'b0;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Port B pin drivers
   // ------------------------------------------------------------
   always @* begin
      pb_out_next = pb_data_reg;
      pb_oe_n_next = pb_dir_reg;
      if (f3 == `SEL_ALT1 || f3 == `SEL_ALT2) begin
         pb_out_next[3] = 1'b0;
         pb_oe_n_next[3] = 1'b1;
      end
      if (f2 == `SEL_ALT1) begin
         pb_out_next[2] = 1'b0;
         pb_oe_n_next[2] = 1'b1;
      end else if (f2 == `SEL_ALT2) begin
         pb_out_next[2] = spi_master_on ? serial_clock_out_i : 1'b0;
         pb_oe_n_next[2] = ~spi_master_on;
      end
      if (f1 == `SEL_ALT1) begin
         pb_out_next[1] = powerline_transmit_out_i;
         pb_oe_n_next[1] = 1'b0;
      end else if (f1 == `SEL_ALT2) begin
         pb_out_next[1] = serial_data_out_i;
         pb_oe_n_next[1] = 1'b0;
      end
      if (f0 == `SEL_ALT1 || f0 == `SEL_ALT3) begin
         pb_out_next[0] = 1'b0;
         pb_oe_n_next[0] = 1'b1;
      end else if (f0 == `SEL_ALT2) begin
         pb_out_next[0] = standard_timer_out_i;
         pb_oe_n_next[0] = 1'b0;
      end
      if (f4 == `SEL_ALT1) begin
         pb_out_next[4] = 1'b0;
         pb_oe_n_next[4] = 1'b1;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         pa_out_o <= `RST_DATA;
         pa_oe_n_o <= `RST_DIR;
         pb_out_o <= `RST_PB;
         pb_oe_n_o <= `RST_PB;
      end else begin
         pa_out_o <= pa_out_next;
         pa_oe_n_o <= pa_oe_n_next;
         pb_out_o <= pb_out_next;
         pb_oe_n_o <= pb_oe_n_next;
      end
   end

   // ------------------------------------------------------------
   // Peripheral input routing
   // ------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         powerline_receive_in_o <= 1'b0;
         serial_data_in_o <= 1'b0;
         serial_clock_in_o <= 1'b0;
         serial_chip_select_o <= 1'b0;
         periodic_timer_capture_in_o <= 1'b0;
         external_irq0_o <= 1'b0;
         powerline_sink_node_sel_o <= 1'b0;
         opamp0_inverting_in_sel_o <= 1'b0;
      end else begin
         powerline_receive_in_o <= (f3 == `SEL_ALT1) & pb_s[3];
         external_irq0_o <= (f0 == `SEL_GPIO) & pb_s[0];
         opamp0_inverting_in_sel_o <= (f0 == `SEL_ALT3);
         powerline_sink_node_sel_o <= (f2 == `SEL_ALT1);
         if (input_source_select_reg[`IFS_CAP_HI:`IFS_CAP_LO] == `SEL_ALT1) begin
            periodic_timer_capture_in_o <= pa_s[7];
         end else begin
            periodic_timer_capture_in_o <= powerline_comparator_out_i;
         end
         case (input_source_select_reg[`IFS_SCS_HI:`IFS_SCS_LO])
            `SEL_ALT1: serial_chip_select_o <= pb_s[4];
            `SEL_ALT2: serial_chip_select_o <= pa_s[1];
            default: serial_chip_select_o <= pb_s[0];
         endcase
         case (input_source_select_reg[`IFS_SCK_HI:`IFS_SCK_LO])
            `SEL_GPIO: serial_clock_in_o <= pa_s[0];
            `SEL_ALT2: serial_clock_in_o <= pa_s[7];
            default: serial_clock_in_o <= pb_s[2];
         endcase
         case (input_source_select_reg[`IFS_SDI_HI:`IFS_SDI_LO])
            `SEL_ALT1: serial_data_in_o <= pa_s[6];
            `SEL_ALT2: serial_data_in_o <= pb_s[3];
            default: serial_data_in_o <= pa_s[2];
         endcase
      end
   end

   // ------------------------------------------------------------
   // Port A wake-up
   // ------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         pa_prev_reg <= 8'hff;
         wake_o <= 1'b0;
      end else begin
         pa_prev_reg <= pa_s;
         wake_o <= sleep_i & (|(pa_prev_reg & ~pa_s & porta_wake_enable_reg));
      end
   end
endmodule

// ==== port_b_pin_mux_test.sv ====
// Self-checking bench for the port B pin mux.
`timescale 1ns/1ns
module port_b_pin_mux_test;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [31:0] dat_i = 32'h0;
   logic sleep_i = 1'b0;
   logic tx = 1'b0, sdo = 1'b0, sck = 1'b0, standard_timer_out = 1'b0, cmp = 1'b0;
   logic [7:0] pa_ext = 8'hff;
   logic [4:0] pb_ext = 5'h1f;
   logic [7:0] rd;
   wire [31:0] dat_o;
   wire ack_o, wake_o, rx_o, sdi_o, sck_o, scs_o, cap_o, irq_o, sink_o, opamp_o;
   wire [7:0] pa_in, pa_out, pa_oe_n;
   wire [4:0] pb_in, pb_out, pb_oe_n;
   int err_count = 0;
   int n_tests = 0;
   int wakes = 0;
   typedef struct {logic [7:0] ifs; logic [7:0] pa; logic [4:0] pb; logic cm; logic [3:0] ex;} route_t;
   route_t rows [4] = '{'{8'h00, 8'h05, 5'h01, 1'b1, 4'hf}, '{8'h55, 8'hc0, 5'h14, 1'b0, 4'hf},
      '{8'haa, 8'h82, 5'h08, 1'b1, 4'hf}, '{8'hff, 8'h04, 5'h05, 1'b1, 4'hf}};
   port_b_pin_mux port_b_pin_mux_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(4'h1), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pa_in_i(pa_in), .pa_out_o(pa_out),
      .pa_oe_n_o(pa_oe_n), .pb_in_i(pb_in), .pb_out_o(pb_out), .pb_oe_n_o(pb_oe_n), .sleep_i(sleep_i),
      .wake_o(wake_o), .powerline_transmit_out_i(tx), .serial_data_out_i(sdo), .serial_clock_out_i(sck),
      .standard_timer_out_i(standard_timer_out), .powerline_comparator_out_i(cmp), .powerline_receive_in_o(rx_o),
      .serial_data_in_o(sdi_o), .serial_clock_in_o(sck_o), .serial_chip_select_o(scs_o),
      .periodic_timer_capture_in_o(cap_o), .external_irq0_o(irq_o), .powerline_sink_node_sel_o(sink_o),
      .opamp0_inverting_in_sel_o(opamp_o));
   pin_world pin_world_inst (.pa_out_i(pa_out), .pa_oe_n_i(pa_oe_n), .pb_out_i(pb_out), .pb_oe_n_i(pb_oe_n),
      .pa_board_i(pa_ext), .pb_board_i(pb_ext), .pa_pin_o(pa_in), .pb_pin_o(pb_in));
   initial begin
      forever #4 clk_i = ~clk_i;
   end
   always @(posedge clk_i) if (wake_o === 1'b1) wakes++;
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task finish_test;
      $display("Comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
      int n;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= {idx, 2'b00};
      dat_i <= {24'h0, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 40);
      if (n >= 40) err_count++;
      rd = dat_o[7:0];
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   task rd_chk(input logic [5:0] idx, input logic [7:0] exp, input string name);
      bus(1'b0, idx, 8'h00);
      check_val(name, exp, rd);
   endtask
   task settle;
      repeat (6) @(posedge clk_i);
   endtask
   initial begin
      #160000;
      err_count++;
      finish_test();
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check_val("pins", {8'hff, 8'hff, 5'h1f}, {pa_out, pa_oe_n, pb_oe_n});
      rd_chk(6'h00, 8'hff, "pa_data");
      rd_chk(6'h01, 8'hff, "pa_dir");
      rd_chk(6'h03, 8'h1f, "pb_dir");
      rd_chk(6'h07, 8'h00, "src_sel");
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, 6'h07, rows[i].ifs);
         for (int v = 0; v < 2; v++) begin
            pa_ext <= rows[i].pa ^ {8{v[0]}};
            pb_ext <= rows[i].pb ^ {5{v[0]}};
            cmp <= rows[i].cm ^ v[0];
            settle();
            check_val("routed", rows[i].ex ^ {4{v[0]}}, {cap_o, scs_o, sck_o, sdi_o});
         end
      end
      bus(1'b1, 6'h01, 8'hf7);
      settle();
      check_val("pa_pins", {8'hf7, 8'hff}, {pa_oe_n, pa_out});
      pa_ext <= 8'h00;
      settle();
      bus(1'b1, 6'h09, 8'h03);
      bus(1'b1, 6'h01, 8'h00);
      settle();
      check_val("pa_out_rmw", 8'h00, pa_out);
      bus(1'b1, 6'h09, 8'h1a);
      settle();
      check_val("pa_dir_rmw", 8'h04, pa_oe_n);
      bus(1'b1, 6'h01, 8'hff);
      bus(1'b1, 6'h03, 8'h00);
      settle();
      check_val("pb_gpio", {5'h00, 5'h1f}, {pb_oe_n, pb_out});
      sdo <= 1'b1;
      bus(1'b1, 6'h05, 8'h0a);
      settle();
      check_val("pb_alt2", {5'h00, 2'b10}, {pb_oe_n, pb_out[1:0]});
      tx <= 1'b1;
      pb_ext <= 5'h08;
      bus(1'b1, 6'h05, 8'h57);
      settle();
      check_val("pb_alt1", 8'hdf, {pb_oe_n[3:0], pb_out[1], rx_o, sink_o, opamp_o});
      bus(1'b1, 6'h06, 8'hff);
      rd_chk(6'h06, 8'h03, "high_sel");
      check_val("pb4_code3", 1'b0, pb_oe_n[4]);
      bus(1'b1, 6'h06, 8'h01);
      settle();
      check_val("pb4_code1", 1'b1, pb_oe_n[4]);
      bus(1'b1, 6'h05, 8'h00);
      bus(1'b1, 6'h03, 8'h1f);
      pb_ext <= 5'h01;
      settle();
      check_val("irq0", 1'b1, irq_o);
      sck <= 1'b1;
      bus(1'b1, 6'h05, 8'h20);
      bus(1'b1, 6'h08, 8'h0f);
      settle();
      check_val("sck_drive", 6'h07, {pa_oe_n[7], pa_oe_n[0], pb_oe_n[2], pa_out[7], pa_out[0], pb_out[2]});
      bus(1'b1, 6'h08, 8'h00);
      bus(1'b1, 6'h04, 8'h20);
      pa_ext <= 8'hff;
      sleep_i <= 1'b1;
      settle();
      pa_ext <= 8'hef;
      settle();
      check_val("wake_masked", 32'd0, wakes);
      pa_ext <= 8'hcf;
      settle();
      check_val("wake_enabled", 32'd1, wakes);
      sleep_i <= 1'b0;
      pa_ext <= 8'hff;
      settle();
      pa_ext <= 8'hdf;
      settle();
      check_val("wake_awake", 32'd1, wakes);
      bus(1'b1, 6'h3f, 8'h5a);
      rd_chk(6'h3f, 8'h00, "unmapped");
      finish_test();
   end
endmodule

// ==== port_mux_map.vh ====
// Register indices, field positions, codes and reset values of the port B pin mux.
`ifndef PORT_MUX_MAP_VH
`define PORT_MUX_MAP_VH

`define PA_W 8
`define PB_W 5

`define IDX_PA_DATA 6'h00
`define IDX_PA_DIR 6'h01
`define IDX_PB_DATA 6'h02
`define IDX_PB_DIR 6'h03
`define IDX_PA_WAKE 6'h04
`define IDX_PBS_LOW 6'h05
`define IDX_PBS_HIGH 6'h06
`define IDX_IFS 6'h07
`define IDX_CTRL 6'h08
`define IDX_BITOP 6'h09

`define RST_DATA 8'hff
`define RST_DIR 8'hff
`define RST_ZERO 8'h00
`define RST_PB 5'h1f
`define PBS_HIGH_MASK 8'h03

`define SEL_GPIO 2'h0
`define SEL_ALT1 2'h1
`define SEL_ALT2 2'h2
`define SEL_ALT3 2'h3

`define PB3_HI 7
`define PB3_LO 6
`define PB2_HI 5
`define PB2_LO 4
`define PB1_HI 3
`define PB1_LO 2
`define PB0_HI 1
`define PB0_LO 0
`define PB4_HI 1
`define PB4_LO 0

`define IFS_CAP_HI 7
`define IFS_CAP_LO 6
`define IFS_SCS_HI 5
`define IFS_SCS_LO 4
`define IFS_SCK_HI 3
`define IFS_SCK_LO 2
`define IFS_SDI_HI 1
`define IFS_SDI_LO 0

`define CTRL_SIM_EN 0
`define CTRL_SPI_MASTER 1
`define CTRL_PA0_SCK 2
`define CTRL_PA7_SCK 3
`define CTRL_W 4

`define BITOP_BIT_HI 2
`define BITOP_BIT_LO 0
`define BITOP_SET 3
`define BITOP_TGT_HI 6
`define BITOP_TGT_LO 4

`endif

// ==== port_mux_monitor.sv ====
// Assertion checker for the port B pin mux.
`timescale 1ns/1ns
module port_mux_monitor (
   input wire clk_i,
   input wire rst_i,
   input wire we_i,
   input wire [7:0] adr_i,
   input wire [31:0] dat_i,
   input wire [31:0] dat_o,
   input wire ack_o,
   input wire [7:0] pa_in_i,
   input wire [4:0] pb_in_i,
   input wire [4:0] pb_out_o,
   input wire [4:0] pb_oe_n_o,
   input wire sleep_i,
   input wire wake_o,
   input wire powerline_transmit_out_i,
   input wire powerline_comparator_out_i,
   input wire periodic_timer_capture_in_o,
   input wire serial_chip_select_o,
   input wire serial_data_in_o
);
   logic [7:0] lsel_reg;
   logic [7:0] ifs_reg;
   logic [2:0] quiet_reg;
   wire settled = quiet_reg == 3'h7;
   wire cs_pin = ifs_reg[5:4] == 2'h1 ? pb_in_i[4] : ifs_reg[5:4] == 2'h2 ? pa_in_i[1] : pb_in_i[0];
   wire di_pin = ifs_reg[1:0] == 2'h1 ? pa_in_i[6] : ifs_reg[1:0] == 2'h2 ? pb_in_i[3] : pa_in_i[2];
   // Shadow selects, and cycles since the last write.
   always @(posedge clk_i) begin
      if (rst_i) begin
         lsel_reg <= 8'h00;
         ifs_reg <= 8'h00;
         quiet_reg <= 3'h0;
      end else if (ack_o && we_i) begin
         quiet_reg <= 3'h0;
         lsel_reg <= adr_i[7:2] == 6'h05 ? dat_i[7:0] : lsel_reg;
         ifs_reg <= adr_i[7:2] == 6'h07 ? dat_i[7:0] : ifs_reg;
      end else if (!settled) begin
         quiet_reg <= quiet_reg + 3'h1;
      end
   end
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   reset_ones_a: assert property ($fell(rst_i) |-> pb_out_o == 5'h1f && pb_oe_n_o == 5'h1f)
      else $error("pins not released after reset");
   pb1_tx_a: assert property (settled && lsel_reg[3:2] == 2'h1 |->
      !pb_oe_n_o[1] && pb_out_o[1] == $past(powerline_transmit_out_i)) else $error("pb1 mux");
   cap_pin_a: assert property (settled && ifs_reg[7:6] == 2'h1 |->
      periodic_timer_capture_in_o == $past(pa_in_i[7], 3)) else $error("capture pin");
   cap_cmp_a: assert property (settled && ifs_reg[7:6] != 2'h1 |->
      periodic_timer_capture_in_o == $past(powerline_comparator_out_i)) else $error("capture cmp");
   cs_src_a: assert property (settled |-> serial_chip_select_o == $past(cs_pin, 3))
      else $error("chip select source");
   di_src_a: assert property (settled |-> serial_data_in_o == $past(di_pin, 3))
      else $error("data source");
   hi_sel_a: assert property (ack_o && !we_i && adr_i[7:2] == 6'h06 |-> dat_o[7:2] == 6'h00)
      else $error("high select upper bits");
   wake_sleep_a: assert property (wake_o |-> $past(sleep_i))
      else $error("wake while awake");
   wake_edge_a: assert property (wake_o |-> ($past(pa_in_i, 4) & ~$past(pa_in_i, 3)) != 8'h00)
      else $error("wake without falling edge");
   cover property (settled && ifs_reg[7:6] == 2'h1);
   cover property (settled && lsel_reg[3:2] == 2'h1);
   cover property (wake_o);
endmodule
bind port_b_pin_mux port_mux_monitor mon_inst (.clk_i(clk_i), .rst_i(rst_i), .we_i(we_i), .adr_i(adr_i),
   .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pa_in_i(pa_in_i), .pb_in_i(pb_in_i), .pb_out_o(pb_out_o),
   .pb_oe_n_o(pb_oe_n_o), .sleep_i(sleep_i), .wake_o(wake_o),
   .powerline_transmit_out_i(powerline_transmit_out_i), .powerline_comparator_out_i(powerline_comparator_out_i),
   .periodic_timer_capture_in_o(periodic_timer_capture_in_o), .serial_chip_select_o(serial_chip_select_o),
   .serial_data_in_o(serial_data_in_o));
